// ### rtl/rtpf_top.sv
// design: registered octal transceiver with parity and handshake flags
`timescale 1ns/1ps
module rtpf_top #(
    parameter int DATA_W = rtpf_pkg::DATA_W
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic A_TO_B_CLOCK,
    input wire logic A_TO_B_LOAD_ENABLE_N,
    input wire logic B_TO_A_CLOCK,
    input wire logic B_TO_A_LOAD_ENABLE_N,
    input wire logic B_SIDE_OUTPUT_ENABLE_N,
    input wire logic A_SIDE_OUTPUT_ENABLE_N,
    input wire logic [DATA_W-1:0] A_PORT_BUS_I,
    output logic [DATA_W-1:0] A_PORT_BUS_O,
    output logic A_PORT_BUS_OE,
    input wire logic [DATA_W-1:0] B_PORT_BUS_I,
    output logic [DATA_W-1:0] B_PORT_BUS_O,
    output logic B_PORT_BUS_OE,
    input wire logic PARITY_I,
    output logic PARITY_O,
    output logic PARITY_OE,
    output logic ERROR_N,
    output logic A_TO_B_FULL_FLAG,
    output logic B_TO_A_FULL_FLAG,
    output logic B_READY,
    output logic B_WORD_VALID,
    input wire logic B_WORD_READY,
    output logic [DATA_W-1:0] B_WORD_DATA
);
    // ============================================================
    // parameter check
    if (DATA_W != rtpf_pkg::DATA_W) begin : g_width_check
        $error("DATA_W must match the packed carrier width");
    end

    // ============================================================
    // pin synchronisers, two stages, first stage read only by second
    rtpf_pkg::rtpf_side_t meta_a, sync_a, prev_a;
    rtpf_pkg::rtpf_side_t meta_b, sync_b, prev_b;
    rtpf_pkg::rtpf_side_t pin_a, pin_b;

    always_comb begin
        pin_a = '{clk: A_TO_B_CLOCK, load_en_n: A_TO_B_LOAD_ENABLE_N,
                  oe_n: A_SIDE_OUTPUT_ENABLE_N, data: A_PORT_BUS_I, par: 1'b0};
        pin_b = '{clk: B_TO_A_CLOCK, load_en_n: B_TO_A_LOAD_ENABLE_N,
                  oe_n: B_SIDE_OUTPUT_ENABLE_N, data: B_PORT_BUS_I, par: PARITY_I};
    end

    // output enables idle high so no false rise right after reset
    localparam rtpf_pkg::rtpf_side_t SIDE_RST = '{clk: 1'b0, load_en_n: 1'b1,
        oe_n: 1'b1, data: rtpf_pkg::DATA_RST, par: rtpf_pkg::PAR_RST};

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            meta_a <= SIDE_RST;
            sync_a <= SIDE_RST;
            prev_a <= SIDE_RST;
            meta_b <= SIDE_RST;
            sync_b <= SIDE_RST;
            prev_b <= SIDE_RST;
        end else begin
            meta_a <= pin_a;
            sync_a <= meta_a;
            prev_a <= sync_a;
            meta_b <= pin_b;
            sync_b <= meta_b;
            prev_b <= sync_b;
        end
    end

    // edge events; data sampled at the synchronised clock rise, so pins must be
    // stable two system cycles around the edge (limitation of oversampling)
    logic load_ab, load_ba, clr_ab, clr_ba;
    always_comb begin
        load_ab = sync_a.clk && !prev_a.clk && !sync_a.load_en_n;
        load_ba = sync_b.clk && !prev_b.clk && !sync_b.load_en_n;
        clr_ab = sync_b.oe_n && !prev_b.oe_n;
        clr_ba = sync_a.oe_n && !prev_a.oe_n;
    end

    // ============================================================
    // registers and flags
    logic [DATA_W-1:0] reg_ab, next_reg_ab, reg_ba, next_reg_ba;
    logic par_ba, next_par_ba;
    logic flag_ab, next_flag_ab, flag_ba, next_flag_ba;

    always_comb begin
        next_reg_ab = reg_ab;
        next_reg_ba = reg_ba;
        next_par_ba = par_ba;
        next_flag_ab = flag_ab;
        next_flag_ba = flag_ba;
        if (clr_ab) begin
            next_flag_ab = 1'b0;
        end
        if (clr_ba) begin
            next_flag_ba = 1'b0;
        end
        if (load_ab) begin
            next_reg_ab = sync_a.data;
            next_flag_ab = 1'b1;
        end
        if (load_ba) begin
            next_reg_ba = sync_b.data;
            next_par_ba = sync_b.par;
            next_flag_ba = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            reg_ab <= rtpf_pkg::DATA_RST;
            reg_ba <= rtpf_pkg::DATA_RST;
            par_ba <= rtpf_pkg::PAR_RST;
            flag_ab <= rtpf_pkg::FLAG_RST;
            flag_ba <= rtpf_pkg::FLAG_RST;
        end else begin
            reg_ab <= next_reg_ab;
            reg_ba <= next_reg_ba;
            par_ba <= next_par_ba;
            flag_ab <= next_flag_ab;
            flag_ba <= next_flag_ba;
        end
    end

    // ============================================================
    // pin drivers, registered; enable pins low means driving
    logic [DATA_W-1:0] next_a_o, next_b_o;
    logic next_a_oe, next_b_oe, next_par_o, next_err_n;

    always_comb begin
        next_b_o = reg_ab;
        next_b_oe = sync_b.oe_n;
        next_par_o = ~(^reg_ab);
        next_a_o = reg_ba;
        next_a_oe = sync_a.oe_n;
        next_err_n = sync_a.oe_n ? 1'b1 : ^{reg_ba, par_ba};
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            A_PORT_BUS_O <= rtpf_pkg::DATA_RST;
            B_PORT_BUS_O <= rtpf_pkg::DATA_RST;
            A_PORT_BUS_OE <= rtpf_pkg::OE_N_RST;
            B_PORT_BUS_OE <= rtpf_pkg::OE_N_RST;
            PARITY_O <= rtpf_pkg::PAR_RST;
            ERROR_N <= rtpf_pkg::ERR_N_RST;
        end else begin
            A_PORT_BUS_O <= next_a_o;
            B_PORT_BUS_O <= next_b_o;
            A_PORT_BUS_OE <= next_a_oe;
            B_PORT_BUS_OE <= next_b_oe;
            PARITY_O <= next_par_o;
            ERROR_N <= next_err_n;
        end
    end

    assign PARITY_OE = B_PORT_BUS_OE;
    assign A_TO_B_FULL_FLAG = flag_ab;
    assign B_TO_A_FULL_FLAG = flag_ba;

    // ============================================================
    // two-entry buffer copying each A-to-B load for an on-chip consumer;
    // a load arriving at a full buffer is not copied, and B_READY shows low
    rtpf_pkg::rtpf_word_t buf_mem [rtpf_pkg::BUF_DEPTH];
    logic wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [1:0] count, next_count;
    logic push, pop;

    always_comb begin
        B_READY = (count != 2'(rtpf_pkg::BUF_DEPTH));
        B_WORD_VALID = (count != 2'h0);
        push = load_ab && B_READY;
        pop = B_WORD_VALID && B_WORD_READY;
        next_wr_ptr = push ? ~wr_ptr : wr_ptr;
        next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
        next_count = count + 2'(push) - 2'(pop);
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (push) begin
            buf_mem[wr_ptr] <= '{data: sync_a.data, par: ~(^sync_a.data)};
        end
    end

    assign B_WORD_DATA = buf_mem[rd_ptr].data;

    // ============================================================
    // checks
    a_load_sets_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
        load_ab |=> flag_ab && reg_ab == $past(sync_a.data))
        else $error("a-to-b load did not set flag or store data");
    a_hold_no_load: assert property (@(posedge CLK_SYS) disable iff (RST)
        !load_ab |=> $stable(reg_ab))
        else $error("a-to-b register changed without a load");
    a_clear_ab_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
        (clr_ab && !load_ab) |=> !flag_ab)
        else $error("a-to-b flag not cleared by output enable rise");
    a_clear_ba_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
        (clr_ba && !load_ba) |=> !flag_ba)
        else $error("b-to-a flag not cleared by output enable rise");
    a_set_wins: assert property (@(posedge CLK_SYS) disable iff (RST)
        (load_ba && clr_ba) |=> flag_ba)
        else $error("clear beat a coinciding load");
    a_set_wins_ab: assert property (@(posedge CLK_SYS) disable iff (RST)
        (load_ab && clr_ab) |=> flag_ab)
        else $error("clear beat a coinciding a-to-b load");
    a_parity_even: assert property (@(posedge CLK_SYS) disable iff (RST)
        !PARITY_OE |-> PARITY_O == ~(^B_PORT_BUS_O))
        else $error("generated parity wrong");
    a_error_check: assert property (@(posedge CLK_SYS) disable iff (RST)
        $past(sync_a.oe_n) |-> ERROR_N)
        else $error("error output low while disabled");
    a_b_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
        !sync_b.oe_n |=> !B_PORT_BUS_OE && B_PORT_BUS_O == $past(reg_ab))
        else $error("b port not driving the a-to-b register");
    a_ba_load: assert property (@(posedge CLK_SYS) disable iff (RST)
        load_ba |=> flag_ba && par_ba == $past(sync_b.par))
        else $error("b-to-a load failed");
endmodule

// ### inc/rtpf_pkg.sv
// package: constants and carrier types for the registered parity transceiver
// ============================================================
// Overview of operation
// - two independent 8-bit registers, one per direction, each own clock and enable
// - a_to_b clock rise with load enable low stores A port into A-to-B register
// - that qualified load also sets the A-to-B full flag high
// - enable high or no clock rise: register and flag keep contents
// - B-side output enable low drives A-to-B register onto B port
// - each output buffer floats while its enable is high, follows register when low
// - parity output high for even ones count in A-to-B register, floats if disabled
// - B-side output enable rising clears A-to-B flag unless a qualified load coincides
// - b_to_a qualified clock rise stores B port and parity pin input
// - that qualified load also sets the B-to-A full flag high
// - A-side output enable low drives B-to-A register onto A port
// - A-side output enable rising clears the B-to-A flag unless a qualified load coincides
// - error output high on odd ones over nine stored bits; high when disabled
package rtpf_pkg;
    localparam int DATA_W = 8;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;
    localparam logic PAR_RST = 1'b0;
    localparam logic OE_N_RST = 1'b1;
    localparam logic ERR_N_RST = 1'b1;
    localparam int BUF_DEPTH = 2;

    // one side's pin inputs after synchronising
    typedef struct packed {
        logic clk;
        logic load_en_n;
        logic oe_n;
        logic [DATA_W-1:0] data;
        logic par;
    } rtpf_side_t;

    // word moving through the skid buffer
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic par;
    } rtpf_word_t;
endpackage

// ### dv/rtpf_reader.sv
// partner: consumer of the on-chip word buffer, able to stall
`timescale 1ns/1ps
module rtpf_reader (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic valid,
    output logic ready,
    input wire logic [rtpf_pkg::DATA_W-1:0] data,
    output logic [rtpf_pkg::DATA_W-1:0] last,
    output int count
);
    assign ready = !stall;
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= 0;
            last <= 8'h00;
        end else if (valid && ready) begin
            count <= count + 1;
            last <= data;
        end
    end
endmodule

// ### dv/tb_top.sv
// testbench: pin-level scenarios for the registered parity transceiver
`timescale 1ns/1ps
module tb_top;
    localparam int W = rtpf_pkg::DATA_W;
    localparam logic [W-1:0] AB_V [5] = '{8'h00, 8'h80, 8'h07, 8'hFF, 8'h5A};
    localparam logic [W-1:0] BA_V [4] = '{8'h00, 8'h00, 8'h07, 8'hFE};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic stall = 1'b0;
    logic par_i = 1'b0;
    // index 0: A-to-B direction and B side, index 1: B-to-A direction and A side
    logic [1:0] pclk = 2'h0, pen_n = 2'h3, oe_n = 2'h3;
    logic [W-1:0] a_i = 8'h00, b_i = 8'h00, a_o, b_o, word, last;
    logic a_oe, b_oe, par_o, par_oe, err_n, ab_flag, ba_flag, b_rdy, w_valid, w_ready;
    int count;
    int n_errors = 0;
    int num_checks = 0;
    always #20 clk_sys = ~clk_sys;

    rtpf_top DUT (
        .CLK_SYS(clk_sys), .RST(rst), .A_TO_B_CLOCK(pclk[0]), .A_TO_B_LOAD_ENABLE_N(pen_n[0]),
        .B_TO_A_CLOCK(pclk[1]), .B_TO_A_LOAD_ENABLE_N(pen_n[1]),
        .B_SIDE_OUTPUT_ENABLE_N(oe_n[0]), .A_SIDE_OUTPUT_ENABLE_N(oe_n[1]),
        .A_PORT_BUS_I(a_i), .A_PORT_BUS_O(a_o), .A_PORT_BUS_OE(a_oe),
        .B_PORT_BUS_I(b_i), .B_PORT_BUS_O(b_o), .B_PORT_BUS_OE(b_oe),
        .PARITY_I(par_i), .PARITY_O(par_o), .PARITY_OE(par_oe), .ERROR_N(err_n),
        .A_TO_B_FULL_FLAG(ab_flag), .B_TO_A_FULL_FLAG(ba_flag), .B_READY(b_rdy),
        .B_WORD_VALID(w_valid), .B_WORD_READY(w_ready), .B_WORD_DATA(word));
    rtpf_reader reader (.clk(clk_sys), .rst(rst), .stall(stall), .valid(w_valid),
        .ready(w_ready), .data(word), .last(last), .count(count));

    // ============================================================
    // shared tasks
    task automatic step(int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic check(string what, logic [W-1:0] seen, logic [W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // pin clock held low and high 3 cycles each, so the synchroniser never misses it
    task automatic pulse(int s, logic en_n);
        pen_n[s] <= en_n;
        step(3);
        pclk[s] <= 1'b1;
        step(3);
        pclk[s] <= 1'b0;
        pen_n[s] <= 1'b1;
        step(3);
    endtask
    task automatic oe(int s, logic v);
        oe_n[s] <= v;
        step(5);
    endtask

    // ============================================================
    // scenarios
    task automatic t_ab(logic [W-1:0] d);
        a_i <= d;
        pulse(0, 1'b0);
        check("ab flag", ab_flag, 1'h1);
        check("b oe idle", {b_oe, par_oe}, 2'h3);
        oe(0, 1'b0);
        check("b data", b_o, d);
        check("b oe", {b_oe, par_oe}, 2'h0);
        check("parity", par_o, ~^d);
        oe(0, 1'b1);
        check("ab flag clr", ab_flag, 1'h0);
    endtask
    task automatic t_hold();
        a_i <= 8'hA5;
        pulse(0, 1'b1);
        check("hold flag", ab_flag, 1'h0);
        oe(0, 1'b0);
        check("hold data", b_o, 8'h5A);
        oe(0, 1'b1);
    endtask
    task automatic t_ba(logic [W-1:0] d, logic p);
        b_i <= d;
        par_i <= p;
        pulse(1, 1'b0);
        check("ba flag", ba_flag, 1'h1);
        check("err idle", err_n, 1'h1);
        check("a oe idle", a_oe, 1'h1);
        oe(1, 1'b0);
        check("a oe", a_oe, 1'h0);
        check("a data", a_o, d);
        check("err", err_n, ^{d, p});
        oe(1, 1'b1);
        check("ba flag clr", ba_flag, 1'h0);
    endtask
    // s picks the direction: load edge and clearing enable rise reach the sync together
    task automatic t_coincide(int s);
        logic [1:0] flags;
        a_i <= 8'h3C;
        oe(s, 1'b0);
        pen_n[s] <= 1'b0;
        step(3);
        pclk[s] <= 1'b1;
        oe_n[s] <= 1'b1;
        step(6);
        flags = {ba_flag, ab_flag};
        check("set wins", flags[s], 1'h1);
        pclk[s] <= 1'b0;
        pen_n[s] <= 1'b1;
        oe(s, 1'b0);
        oe(s, 1'b1);
        flags = {ba_flag, ab_flag};
        check("clr after", flags[s], 1'h0);
    endtask
    // reset in mid-run must drop a set flag and the stored word
    task automatic t_reset();
        a_i <= 8'hC3;
        pulse(0, 1'b0);
        rst <= 1'b1;
        step(2);
        rst <= 1'b0;
        step(4);
        check("rst mid flag", ab_flag, 1'h0);
        oe(0, 1'b0);
        check("rst mid data", b_o, 8'h00);
        oe(0, 1'b1);
    endtask
    // reader stalls while three loads arrive: two fit, the third finds no room
    task automatic t_buffer();
        int base;
        base = count;
        stall <= 1'b1;
        a_i <= 8'h11;
        pulse(0, 1'b0);
        a_i <= 8'h22;
        pulse(0, 1'b0);
        a_i <= 8'h33;
        pulse(0, 1'b0);
        check("buf full", {b_rdy, w_valid}, 2'h1);
        check("buf head", word, 8'h11);
        stall <= 1'b0;
        step(4);
        check("drained", 8'(count - base), 8'h02);
        check("last word", last, 8'h22);
        check("empty", w_valid, 1'h0);
        oe(0, 1'b0);
        check("reg kept load", b_o, 8'h33);
        oe(0, 1'b1);
    endtask

    // ============================================================
    // main sequence and watchdog
    initial begin
        step(12);
        rst <= 1'b0;
        step(4);
        check("rst oe", {a_oe, b_oe, par_oe, err_n}, 4'hF);
        check("rst flags", {ab_flag, ba_flag}, 2'h0);
        foreach (AB_V[i]) t_ab(AB_V[i]);
        t_hold();
        foreach (BA_V[i]) t_ba(BA_V[i], i[0]);
        t_coincide(0);
        t_coincide(1);
        t_buffer();
        t_reset();
        report_and_stop();
    end
    initial begin
        step(5000);
        n_errors++;
        report_and_stop();
    end
endmodule
